// *** src/afil_defines.vh ***
// Purpose: Constants for the arithmetic fault indicator latches
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes: Included by the fault latch top module
`ifndef AFIL_DEFINES_VH
`define AFIL_DEFINES_VH
`define AFIL_OFS_STATUS 5'h00
`define AFIL_OFS_MASK 5'h04
`define AFIL_OFS_INHIBIT 5'h08
`define AFIL_OFS_CONTROL 5'h0c
`define AFIL_OFS_LAMPS 5'h10
`define AFIL_NUM_FAULTS 14
`define AFIL_BIT_MIN_OE 0
`define AFIL_BIT_MIN_OE_LO 1
`define AFIL_BIT_MIN_CMP 2
`define AFIL_BIT_SUB_OE 3
`define AFIL_BIT_SUB_OE_LO 4
`define AFIL_BIT_SUB_CMP 5
`define AFIL_BIT_ALPHA_U 6
`define AFIL_BIT_ALPHA_B 7
`define AFIL_BIT_SUM_CMP 8
`define AFIL_BIT_REG0 9
`define AFIL_BIT_BRANCH 13
`define AFIL_RST_MASK 14'h0000
`define AFIL_RST_INHIBIT 14'h0000
`define AFIL_RST_CONTROL 2'h0
`define AFIL_CTL_EARLY 0
`define AFIL_CTL_CLEAR 1
`define AFIL_RESP_OKAY 2'h0
`define AFIL_RESP_SLVERR 2'h2
`endif

// *** src/afil_latch.v ***
// Purpose: One sticky fault latch with inhibit gate
// Assumes: Synchronous reset, clock enable freezes state
// Notes: Set wins over clear
`timescale 1ns/100ps
`default_nettype none
module afil_latch (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire fault,
    input wire inhibit,
    input wire clear,
    output reg latched
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            latched <= 1'b0;
        end else if (ce) begin
            if (fault && !inhibit) begin
                latched <= 1'b1;
            end else if (clear) begin
                latched <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** src/afil_top.v ***
// Purpose: Fault capture lamps for the duplicated serial arithmetic section
// Assumes: Datapath check inputs synchronous to aclk; start bar is a level
// Notes: Lamps also readable and maskable as interrupts over AXI4-Lite
// Behaviour
// - The minuend parity lamp lights when the unbarred minuend digit has even pulse count.
// - Outside the early variant, the minuend mismatch lamp lights on disagreement of the two minuend copies and holds.
// - The subtrahend parity lamp lights when the unbarred subtrahend digit has even count.
// - Outside the early variant, the subtrahend mismatch lamp lights on disagreement of the subtrahend copies and holds.
// - During eleven-place additions, simultaneous alphabetic inputs raise the alphabetic fault.
// - A non-sign character in the sign digit position also raises the alphabetic fault.
// - Unbarred and barred alphabetic detectors each drive their own lamp, upper and lower.
// - The sum mismatch lamp lights when the two adder sums disagree and holds.
// - Four register mismatch lamps light on disagreement of each duplicated register pair.
// - The branch mismatch flip-flop sets when the two conditional-transfer flops differ.
// - Every lamp stays latched until the start bar or the control register clear bit clears it.
// - In the early variant the parity lamps show unbarred (upper) and barred (lower) checkers.
// - An inhibit switch blocks its checker output and lights the error-delete indicator.
`timescale 1ns/100ps
`default_nettype none
`include "afil_defines.vh"
module afil_top #(
    parameter DIGIT_W = 7,
    parameter NREG = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire digit_strobe,
    input wire [DIGIT_W-1:0] min_u,
    input wire [DIGIT_W-1:0] min_b,
    input wire [DIGIT_W-1:0] sub_u,
    input wire [DIGIT_W-1:0] sub_b,
    input wire [DIGIT_W-1:0] sum_u,
    input wire [DIGIT_W-1:0] sum_b,
    input wire add11_active,
    input wire sign_time,
    input wire min_alpha_u,
    input wire sub_alpha_u,
    input wire min_alpha_b,
    input wire sub_alpha_b,
    input wire sign_valid_u,
    input wire sign_valid_b,
    input wire [NREG-1:0] reg_bit_u,
    input wire [NREG-1:0] reg_bit_b,
    input wire cond_transfer_u,
    input wire cond_transfer_b,
    input wire start_bar,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [13:0] lamp,
    output reg error_delete_lamp,
    output reg irq
);
    localparam NF = `AFIL_NUM_FAULTS;
    ////////////////////////////////////////////////////////////////////////////////
    // Fault detection
    reg [NF-1:0] mask;
    reg [NF-1:0] inhibit;
    reg early_variant;
    reg sw_clear;
    wire [NF-1:0] fault;
    wire [NF-1:0] latched;
    wire min_even_u = digit_strobe && !(^min_u);
    wire min_even_b = digit_strobe && !(^min_b);
    wire sub_even_u = digit_strobe && !(^sub_u);
    wire sub_even_b = digit_strobe && !(^sub_b);
    wire alpha_u = add11_active && ((min_alpha_u && sub_alpha_u) ||
        (sign_time && !sign_valid_u));
    wire alpha_b = add11_active && ((min_alpha_b && sub_alpha_b) ||
        (sign_time && !sign_valid_b));
    assign fault[`AFIL_BIT_MIN_OE] = min_even_u;
    assign fault[`AFIL_BIT_MIN_OE_LO] = early_variant && min_even_b;
    assign fault[`AFIL_BIT_MIN_CMP] = !early_variant && digit_strobe && (min_u != min_b);
    assign fault[`AFIL_BIT_SUB_OE] = sub_even_u;
    assign fault[`AFIL_BIT_SUB_OE_LO] = early_variant && sub_even_b;
    assign fault[`AFIL_BIT_SUB_CMP] = !early_variant && digit_strobe && (sub_u != sub_b);
    assign fault[`AFIL_BIT_ALPHA_U] = alpha_u;
    assign fault[`AFIL_BIT_ALPHA_B] = alpha_b;
    assign fault[`AFIL_BIT_SUM_CMP] = digit_strobe && (sum_u != sum_b);
    assign fault[`AFIL_BIT_BRANCH] = cond_transfer_u ^ cond_transfer_b;
    wire clear_all = start_bar || sw_clear;
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
            assign fault[`AFIL_BIT_REG0 + gi] = reg_bit_u[gi] ^ reg_bit_b[gi];
        end
        for (gi = 0; gi < NF; gi = gi + 1) begin : g_latch
            afil_latch u_latch (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .fault(fault[gi]),
                .inhibit(inhibit[gi]),
                .clear(clear_all),
                .latched(latched[gi])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////////////
    // Lamp and interrupt outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            lamp <= 14'h0000;
            error_delete_lamp <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            lamp <= latched;
            error_delete_lamp <= |inhibit;
            irq <= |(latched & mask);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    reg [4:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg aw_held;
    reg w_held;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire [4:0] eff_addr = aw_take ? s_axi_awaddr[4:0] : wr_addr;
    wire [31:0] eff_data = w_take ? s_axi_wdata : wr_data;
    // Strobes travel with the data beat, which may be taken before the address
    wire [3:0] eff_strb = w_take ? s_axi_wstrb : wr_strb;
    wire wr_hit = (s_axi_awaddr[31:5] == 27'h0000000) || aw_held;
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AFIL_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 5'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            mask <= `AFIL_RST_MASK;
            inhibit <= `AFIL_RST_INHIBIT;
            early_variant <= 1'b0;
            sw_clear <= 1'b0;
        end else if (ce) begin
            sw_clear <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (aw_take) begin
                aw_held <= 1'b1;
                wr_addr <= (s_axi_awaddr[31:5] == 27'h0000000) ? s_axi_awaddr[4:0] : 5'h1f;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `AFIL_RESP_OKAY;
                if (!wr_hit) begin
                    s_axi_bresp <= `AFIL_RESP_SLVERR;
                end else begin
                    case (eff_addr)
                        `AFIL_OFS_STATUS: begin
                            // Read only: latched faults leave only by a clear
                        end
                        `AFIL_OFS_MASK: begin
                            if (eff_strb[0]) mask[7:0] <= eff_data[7:0];
                            if (eff_strb[1]) mask[13:8] <= eff_data[13:8];
                        end
                        `AFIL_OFS_INHIBIT: begin
                            if (eff_strb[0]) inhibit[7:0] <= eff_data[7:0];
                            if (eff_strb[1]) inhibit[13:8] <= eff_data[13:8];
                        end
                        `AFIL_OFS_CONTROL: begin
                            if (eff_strb[0]) begin
                                early_variant <= eff_data[`AFIL_CTL_EARLY];
                                sw_clear <= eff_data[`AFIL_CTL_CLEAR];
                            end
                        end
                        `AFIL_OFS_LAMPS: begin
                        end
                        default: begin
                            s_axi_bresp <= `AFIL_RESP_SLVERR;
                        end
                    endcase
                end
            end
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AFIL_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `AFIL_RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                if (s_axi_araddr[31:5] != 27'h0000000) begin
                    s_axi_rresp <= `AFIL_RESP_SLVERR;
                end else begin
                    case (s_axi_araddr[4:0])
                        `AFIL_OFS_STATUS: s_axi_rdata <= {18'h00000, latched};
                        `AFIL_OFS_MASK: s_axi_rdata <= {18'h00000, mask};
                        `AFIL_OFS_INHIBIT: s_axi_rdata <= {18'h00000, inhibit};
                        `AFIL_OFS_CONTROL: s_axi_rdata <= {31'h00000000, early_variant};
                        `AFIL_OFS_LAMPS: s_axi_rdata <= {17'h00000, error_delete_lamp, lamp};
                        default: s_axi_rresp <= `AFIL_RESP_SLVERR;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/afil_top_monitor.sv ***
// Purpose: Port checker for the fault latches
// Assumes: ce held high
// Notes: Bound to afil_top
`timescale 1ns/100ps
`default_nettype none
module afil_top_monitor #(parameter DIGIT_W = 7, parameter NREG = 4) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic digit_strobe, add11_active, sign_time, start_bar,
    input wire logic [DIGIT_W-1:0] min_u,
    input wire logic [NREG-1:0] reg_bit_u, reg_bit_b,
    input wire logic cond_transfer_u, cond_transfer_b,
    input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [13:0] lamp,
    input wire logic error_delete_lamp, irq
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
AST_PAR: assert property (digit_strobe && !(^min_u) && !error_delete_lamp |-> ##2 lamp[0])
    else $error("parity lamp missed");
AST_REG: assert property (!error_delete_lamp && reg_bit_u != reg_bit_b |-> ##2
    (lamp[12:9] & $past(reg_bit_u ^ reg_bit_b, 2)) == $past(reg_bit_u ^ reg_bit_b, 2))
    else $error("register lamp missed");
AST_BR: assert property (!error_delete_lamp && cond_transfer_u != cond_transfer_b |-> ##2 lamp[13])
    else $error("branch lamp missed");
AST_HOLD: assert property (|($past(lamp) & ~lamp) |-> $past(start_bar, 2) ||
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("lamp dropped without clear");
AST_CLR: assert property (start_bar && !digit_strobe && !add11_active && !sign_time &&
    reg_bit_u == reg_bit_b && cond_transfer_u == cond_transfer_b |-> ##2 lamp == 14'h0000)
    else $error("clear failed");
AST_IRQ: assert property (irq |-> (|lamp) || (|$past(lamp)))
    else $error("irq without lamp");
AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
AST_RVAL: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
endmodule
bind afil_top afil_top_monitor #(.DIGIT_W(DIGIT_W), .NREG(NREG)) i_mon (.*);
`default_nettype wire

// *** sim/afil_panel_model.sv ***
// Purpose: Duplicated datapath model with fault injection
// Assumes: Code 15 idle, no digit strobe
// Notes: Good digits carry odd pulse counts
`timescale 1ns/100ps
`default_nettype none
module afil_panel_model (
    input wire logic aclk,
    input wire logic [3:0] code,
    output logic [41:0] dig,
    output logic [8:0] flg,
    output logic [9:0] rb
);
always @(posedge aclk) begin
    dig <= {6{7'h01}};
    flg <= (code == 4'hf) ? 9'h003 : 9'h103;
    rb <= 10'h000;
    case (code)
        4'h1: dig[41:28] <= {2{7'h03}};
        4'h2: dig[34:28] <= 7'h02;
        4'h3: dig[27:14] <= {2{7'h03}};
        4'h4: dig[20:14] <= 7'h02;
        4'h5: dig[6:0] <= 7'h02;
        4'h6: flg <= 9'h197;
        4'h7: flg <= 9'h1c1;
        4'h8, 4'h9, 4'ha, 4'hb: rb <= 10'h040 << (code - 4'h8);
        4'hc: rb <= 10'h002;
        4'hd: dig[34:28] <= 7'h03;
        4'he: dig[20:14] <= 7'h03;
        default: ;
    endcase
end
endmodule
`default_nettype wire

// *** sim/afil_top_tb_top.sv ***
// Purpose: Self-checking bench for afil_top
// Assumes: ce, bready, rready and wstrb held
// Notes: Faults come from the panel model
`timescale 1ns/100ps
`default_nettype none
module afil_top_tb_top;
logic aclk = 0, aresetn = 0, ce = 1, start_bar = 0, s_axi_bready = 1, s_axi_rready = 1;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rd_d;
logic [3:0] s_axi_wstrb = 4'hf, code = 4'hf;
logic [1:0] rd_r, wr_r;
wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire logic [1:0] s_axi_bresp, s_axi_rresp;
wire logic [31:0] s_axi_rdata;
wire logic [13:0] lamp;
wire logic error_delete_lamp, irq, digit_strobe, add11_active, sign_time, cond_transfer_u;
wire logic min_alpha_u, min_alpha_b, sub_alpha_u, sub_alpha_b, sign_valid_u, sign_valid_b;
wire logic cond_transfer_b;
wire logic [6:0] min_u, min_b, sub_u, sub_b, sum_u, sum_b;
wire logic [3:0] reg_bit_u, reg_bit_b;
logic [13:0] exp_l [1:14] = '{14'h0001, 14'h0004, 14'h0008, 14'h0020, 14'h0100, 14'h0080,
    14'h0040, 14'h0200, 14'h0400, 14'h0800, 14'h1000, 14'h2000, 14'h0004, 14'h0020};
int mismatches = 0, checks = 0;
afil_panel_model i_pm (.aclk(aclk), .code(code), .dig({min_u, min_b, sub_u, sub_b, sum_u, sum_b}),
    .flg({digit_strobe, add11_active, sign_time, min_alpha_u, min_alpha_b, sub_alpha_u,
    sub_alpha_b, sign_valid_u, sign_valid_b}),
    .rb({reg_bit_u, reg_bit_b, cond_transfer_u, cond_transfer_b}));
afil_top i_dut (.*);
always #2.5 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////////
task cyc(input int n);
    repeat (n) @(posedge aclk);
endtask
task chk(input [31:0] s, input [31:0] e);
    checks++;
    if (s !== e) begin
        mismatches++;
        $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
endtask
task wr(input [31:0] a, input [31:0] d);
    bit pa, pw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
        @(posedge aclk);
        if (pa && s_axi_awready === 1) begin
            pa = 0;
            s_axi_awvalid <= 0;
        end
        if (pw && s_axi_wready === 1) begin
            pw = 0;
            s_axi_wvalid <= 0;
        end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1);
    wr_r = s_axi_bresp;
endtask
task rd(input [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
endtask
task pulse(input [3:0] k, input logic sb);
    code <= k;
    cyc(1);
    code <= 4'hf;
    start_bar <= sb;
    cyc(1);
    start_bar <= 0;
    cyc(5);
endtask
task fire(input [3:0] k, input [13:0] e);
    pulse(k, 0);
    chk(lamp, e);
    cyc(10);
    chk(lamp, e);
    pulse(4'hf, 1);
    chk(lamp, 0);
endtask
////////////////////////////////////////////////////////////////////////////////
task t_rst;
    chk(lamp, 0);
    for (int a = 4; a <= 12; a += 4) begin
        rd(a);
        chk(rd_d, 0);
    end
    rd(32'h14);
    chk(rd_r, 2);
    chk(rd_d, 0);
    wr(32'h14, 0);
    chk(wr_r, 2);
endtask
task t_all;
    for (int k = 1; k <= 14; k++) fire(k[3:0], exp_l[k]);
endtask
task t_early;
    wr(12, 1);
    chk(wr_r, 0);
    rd(12);
    chk(rd_d, 1);
    fire(4'hd, 14'h0002);
    fire(4'he, 14'h0010);
    wr(12, 0);
endtask
task t_race;
    pulse(4'hc, 1);
    chk(lamp, 14'h2000);
    pulse(4'hf, 1);
endtask
task t_inh;
    wr(8, 32'h2000);
    cyc(3);
    chk(error_delete_lamp, 1);
    rd(16);
    chk(rd_d, 32'h4000);
    fire(4'hc, 0);
    wr(8, 0);
    cyc(3);
    chk(error_delete_lamp, 0);
endtask
task t_irq;
    wr(4, 32'h200);
    pulse(4'h8, 0);
    chk(irq, 1);
    rd(0);
    chk(rd_d, 32'h200);
    wr(0, 32'h200);
    rd(0);
    chk(rd_d, 32'h200);
    wr(4, 0);
    cyc(3);
    chk(irq, 0);
    wr(4, 32'h200);
    cyc(3);
    chk(irq, 1);
    wr(12, 2);
    cyc(4);
    chk(lamp, 0);
    chk(irq, 0);
endtask
task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
initial begin
    cyc(20);
    aresetn <= 1;
    t_rst;
    t_all;
    t_early;
    t_race;
    t_inh;
    t_irq;
    tally_and_finish;
end
initial begin
    #100000;
    mismatches++;
    tally_and_finish;
end
endmodule
`default_nettype wire
